// ### rtl/bpc_link.sv
// link controller end: avalon-mm registers, request, byte send and receive over the shared lines
`timescale 1ns/1ps
module bpc_link (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  bpc_link_if.lnk lnk,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_REQ = 3'b001,
    L_WAIT = 3'b010,
    L_SEND = 3'b011
  } bpc_link_state_t;

  bpc_link_state_t state_r;
  // sclk, ctl[1:0], data[1:0]
  logic [4:0] sync1_r, sync2_r;
  logic sclk_d_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] tx_byte_r, rx_byte_r, rx_sh_r;
  logic [1:0] cnt_r, rx_cnt_r;
  logic rx_valid_r, req_r, drive_n_r;
  logic [1:0] ctl_r, data_r;

  wire slot_w = sync2_r[4] && !sclk_d_r;
  wire [1:0] ctl_in_w = sync2_r[3:2];
  wire [1:0] dat_in_w = sync2_r[1:0];
  wire take_w = (avs_read_i || avs_write_i) && !wait_r;
  wire wr_tx_w = take_w && avs_write_i && avs_address_i == bpc_pkg::REG_TX && state_r == L_IDLE;
  wire rd_rx_w = take_w && avs_read_i && avs_address_i == bpc_pkg::REG_RX;
  wire busy_w = state_r != L_IDLE;
  wire [31:0] status_w = {30'h0, rx_valid_r, busy_w};
  wire [31:0] rmux_w = (avs_address_i == bpc_pkg::REG_STATUS) ? status_w :
                       (avs_address_i == bpc_pkg::REG_RX) ? {24'h0, rx_byte_r} : 32'h0;

  always_ff @(posedge clk_sys_i) begin
    sync1_r <= {lnk.system_clock_out, lnk.link_control, lnk.link_data};
    sync2_r <= sync1_r;
  end

  // slave answers with waitrequest low on the second edge of a request
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_r <= 1'b0;
      rdata_r <= rmux_w;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sclk_d_r <= 1'b0;
      state_r <= L_IDLE;
      tx_byte_r <= 8'h00;
      cnt_r <= 2'h0;
      req_r <= 1'b0;
      drive_n_r <= 1'b1;
      ctl_r <= bpc_pkg::CTL_IDLE;
      data_r <= 2'h0;
    end else begin
      sclk_d_r <= sync2_r[4];
      unique case (state_r)
        L_IDLE: if (wr_tx_w) begin
          tx_byte_r <= avs_writedata_i[7:0];
          req_r <= 1'b1;
          state_r <= L_REQ;
        end
        L_REQ: if (slot_w && ctl_in_w == bpc_pkg::CTL_GRANT) begin
          req_r <= 1'b0;
          state_r <= L_WAIT;
        end
        // one slot of turn-around before taking the lines
        L_WAIT: if (slot_w) begin
          drive_n_r <= 1'b0;
          ctl_r <= bpc_pkg::CTL_TX;
          data_r <= tx_byte_r[7:6];
          tx_byte_r <= {tx_byte_r[5:0], 2'h0};
          cnt_r <= 2'h0;
          state_r <= L_SEND;
        end
        L_SEND: if (slot_w) begin
          if (cnt_r == bpc_pkg::DIBIT_LAST) begin
            drive_n_r <= 1'b1;
            ctl_r <= bpc_pkg::CTL_IDLE;
            state_r <= L_IDLE;
          end else begin
            data_r <= tx_byte_r[7:6];
            tx_byte_r <= {tx_byte_r[5:0], 2'h0};
            cnt_r <= cnt_r + 2'h1;
          end
        end
        default: state_r <= L_IDLE;
      endcase
    end
  end

  // received dibits; a completed byte wins over a read that clears valid
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_cnt_r <= 2'h0;
      rx_valid_r <= 1'b0;
    end else begin
      if (slot_w && ctl_in_w == bpc_pkg::CTL_RX && drive_n_r) begin
        rx_sh_r <= {rx_sh_r[5:0], dat_in_w};
        rx_cnt_r <= rx_cnt_r + 2'h1;
      end
      if (slot_w && ctl_in_w == bpc_pkg::CTL_RX && drive_n_r && rx_cnt_r == bpc_pkg::DIBIT_LAST) begin
        rx_byte_r <= {rx_sh_r[5:0], dat_in_w};
        rx_valid_r <= 1'b1;
      end else if (rd_rx_w) begin
        rx_valid_r <= 1'b0;
      end
    end
  end

  assign lnk.service_request_in = req_r;
  assign lnk.lnk_control = ctl_r;
  assign lnk.lnk_data = data_r;
  assign lnk.lnk_drive_n = drive_n_r;
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
endmodule : bpc_link

// ### rtl/bpc_link_if.sv
// shared lines between the transceiver and the link controller
`timescale 1ns/1ps
interface bpc_link_if;
  logic system_clock_out;
  logic system_clock_inverted_out;
  logic service_request_in;
  logic [1:0] dev_control;
  logic [1:0] dev_data;
  logic dev_drive_n;
  logic [1:0] lnk_control;
  logic [1:0] lnk_data;
  logic lnk_drive_n;
  wire [1:0] link_control;
  wire [1:0] link_data;
  // shared lines resolve to the active driver, low when nobody drives
  assign link_control = !dev_drive_n ? dev_control : (!lnk_drive_n ? lnk_control : 2'h0);
  assign link_data = !dev_drive_n ? dev_data : (!lnk_drive_n ? lnk_data : 2'h0);
  modport dev (output system_clock_out, system_clock_inverted_out, dev_control, dev_data, dev_drive_n,
               input service_request_in, link_control, link_data);
  modport lnk (input system_clock_out, system_clock_inverted_out, link_control, link_data,
               output service_request_in, lnk_control, lnk_data, lnk_drive_n);
endinterface : bpc_link_if

// ### rtl/bpc_phy.sv
// transceiver end: clocks, link line turn-around, data-strobe transmit and receive
`timescale 1ns/1ps
module bpc_phy (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  bpc_link_if.dev lnk,
  input wire logic freq_select_strap_i,
  input wire logic test_output_enable_i,
  input wire logic rx_data_i,
  input wire logic rx_strobe_in_i,
  output logic tx_data_o,
  output logic tx_strobe_out_o,
  output logic line_driver_enable_n_o,
  output logic arbitration_clock_test_out_o,
  output logic arbitration_clock_test_out_oe_n_o,
  output logic drive_indicator_test_out_o,
  output logic drive_indicator_test_out_oe_n_o,
  output logic receive_prefix_test_out_o,
  output logic receive_prefix_test_out_oe_n_o
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_GRANT = 3'b001,
    S_TURN_IN = 3'b010,
    S_RECV = 3'b011,
    S_TURN_OUT = 3'b100,
    S_TX = 3'b101
  } bpc_phy_state_t;

  bpc_phy_state_t state_r, state_nxt;
  // pin synchronisers: req, ctl[1:0], data[1:0], rx data, rx strobe, strap, test enable
  logic [8:0] sync1_r, sync2_r;
  logic strap_done_r, slow_r;
  logic [3:0] div_r, arb_div_r;
  logic sclk_r, sclk_n_r, arbitration_clock_test_out_r;
  logic [1:0] ctl_out_r, data_out_r;
  logic drive_n_r;
  logic [7:0] tx_byte_r;
  logic [1:0] dibit_cnt_r;
  logic [2:0] bit_cnt_r;
  logic tx_d_r, tx_s_r, drv_en_n_r;
  logic rx_par_r, rx_first_r, rx_active_r;
  logic [6:0] rx_idle_r;
  logic [1:0] rx_sh_r, rx_dibit_r;
  logic rx_pend_r;
  logic arb_oe_n_r, ind_r, ind_oe_n_r, pre_oe_n_r;

  wire [8:0] pins_w = {lnk.service_request_in, lnk.link_control, lnk.link_data, rx_data_i, rx_strobe_in_i,
                       freq_select_strap_i, test_output_enable_i};
  wire req_w = sync2_r[8];
  wire [1:0] ctl_in_w = sync2_r[7:6];
  wire [1:0] dat_in_w = sync2_r[5:4];
  wire rxd_w = sync2_r[3];
  wire rxs_w = sync2_r[2];
  wire strap_w = sync2_r[1];
  wire test_dis_w = sync2_r[0];
  wire [3:0] half_w = slow_r ? bpc_pkg::HALF_SLOW : bpc_pkg::HALF_FAST;
  wire tick_w = (div_r == half_w - 4'h1);
  wire slot_w = tick_w && !sclk_r;
  wire rx_edge_w = (rxd_w ^ rxs_w) != rx_par_r;
  wire rx_dibit_done_w = rx_edge_w && !rx_first_r;
  wire dev_drives_w = (state_nxt == S_IDLE) || (state_nxt == S_GRANT) || (state_nxt == S_TX);

  always_ff @(posedge clk_sys_i) begin
    sync1_r <= pins_w;
    sync2_r <= sync1_r;
  end

  // strap is caught once after reset release
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      strap_done_r <= 1'b0;
      slow_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      slow_r <= strap_w;
    end
  end

  // system clocks: the inverted copy toggles on the same edge
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      div_r <= 4'h0;
      sclk_r <= 1'b0;
      sclk_n_r <= 1'b1;
    end else if (tick_w) begin
      div_r <= 4'h0;
      sclk_r <= !sclk_r;
      sclk_n_r <= sclk_r;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      arb_div_r <= 4'h0;
      arbitration_clock_test_out_r <= 1'b0;
    end else if (arb_div_r == bpc_pkg::HALF_FAST - 4'h1) begin
      arb_div_r <= 4'h0;
      arbitration_clock_test_out_r <= !arbitration_clock_test_out_r;
    end else begin
      arb_div_r <= arb_div_r + 4'h1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (slot_w) begin
      unique case (state_r)
        S_IDLE: if (req_w && !rx_active_r && !rx_pend_r) state_nxt = S_GRANT;
        S_GRANT: state_nxt = S_TURN_IN;
        S_TURN_IN: state_nxt = S_RECV;
        S_RECV: if (dibit_cnt_r == bpc_pkg::DIBIT_LAST) state_nxt = S_TURN_OUT;
        S_TURN_OUT: state_nxt = S_TX;
        S_TX: state_nxt = S_TX;
        default: state_nxt = S_IDLE;
      endcase
    end
    // the bit counter has wrapped once all eight bits have stood a full half period
    if (state_r == S_TX && tick_w && bit_cnt_r == 3'h0) state_nxt = S_IDLE;
  end

  // link line ownership and the codes placed on them
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r <= S_IDLE;
      ctl_out_r <= bpc_pkg::CTL_IDLE;
      data_out_r <= 2'h0;
      drive_n_r <= 1'b0;
      dibit_cnt_r <= 2'h0;
      tx_byte_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      drive_n_r <= !dev_drives_w;
      // the link's first dibit has settled by the turn-in slot
      if (slot_w && (state_r == S_TURN_IN || state_r == S_RECV) && ctl_in_w == bpc_pkg::CTL_TX) begin
        tx_byte_r <= {tx_byte_r[5:0], dat_in_w};
        dibit_cnt_r <= dibit_cnt_r + 2'h1;
      end
      if (slot_w) begin
        ctl_out_r <= (state_nxt == S_GRANT) ? bpc_pkg::CTL_GRANT :
                     (state_nxt == S_IDLE && rx_pend_r) ? bpc_pkg::CTL_RX : bpc_pkg::CTL_IDLE;
        data_out_r <= (state_nxt == S_IDLE && rx_pend_r) ? rx_dibit_r : 2'h0;
      end
    end
  end

  // serial transmit, strobe toggles when the data bit repeats
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      bit_cnt_r <= 3'h0;
      tx_d_r <= 1'b0;
      tx_s_r <= 1'b0;
      drv_en_n_r <= 1'b1;
    end else begin
      drv_en_n_r <= (state_nxt != S_TX);
      if (tick_w && state_nxt == S_TX) begin
        tx_d_r <= tx_byte_r[3'h7 - bit_cnt_r];
        tx_s_r <= (tx_byte_r[3'h7 - bit_cnt_r] == tx_d_r) ? !tx_s_r : tx_s_r;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // receive decode: each data-strobe transition carries one bit
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_par_r <= 1'b0;
      rx_first_r <= 1'b1;
      rx_active_r <= 1'b0;
      rx_idle_r <= 7'h00;
      rx_sh_r <= 2'h0;
      rx_dibit_r <= 2'h0;
      rx_pend_r <= 1'b0;
    end else begin
      if (rx_edge_w) begin
        rx_par_r <= rxd_w ^ rxs_w;
        rx_sh_r <= {rx_sh_r[0], rxd_w};
        rx_first_r <= !rx_first_r;
        rx_active_r <= 1'b1;
        rx_idle_r <= 7'h00;
      end else if (rx_active_r) begin
        if (rx_idle_r == bpc_pkg::RX_IDLE_CYCLES) begin
          rx_active_r <= 1'b0;
          rx_first_r <= 1'b1;
        end else begin
          rx_idle_r <= rx_idle_r + 7'h01;
        end
      end
      // a new dibit wins over the slot that forwards the old one
      if (rx_dibit_done_w) begin
        rx_dibit_r <= {rx_sh_r[0], rxd_w};
        rx_pend_r <= 1'b1;
      end else if (slot_w && state_nxt == S_IDLE) begin
        rx_pend_r <= 1'b0;
      end
    end
  end

  // test pins, released to high impedance unless enabled
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      arb_oe_n_r <= 1'b1;
      ind_r <= 1'b1;
      ind_oe_n_r <= 1'b1;
      pre_oe_n_r <= 1'b1;
    end else begin
      arb_oe_n_r <= test_dis_w;
      ind_oe_n_r <= test_dis_w;
      pre_oe_n_r <= test_dis_w;
      ind_r <= !dev_drives_w;
    end
  end

  assign lnk.system_clock_out = sclk_r;
  assign lnk.system_clock_inverted_out = sclk_n_r;
  assign lnk.dev_control = ctl_out_r;
  assign lnk.dev_data = data_out_r;
  assign lnk.dev_drive_n = drive_n_r;
  assign tx_data_o = tx_d_r;
  assign tx_strobe_out_o = tx_s_r;
  assign line_driver_enable_n_o = drv_en_n_r;
  assign arbitration_clock_test_out_o = arbitration_clock_test_out_r;
  assign arbitration_clock_test_out_oe_n_o = arb_oe_n_r;
  assign drive_indicator_test_out_o = ind_r;
  assign drive_indicator_test_out_oe_n_o = ind_oe_n_r;
  assign receive_prefix_test_out_o = rx_active_r;
  assign receive_prefix_test_out_oe_n_o = pre_oe_n_r;
endmodule : bpc_phy

// ### rtl/bpc_pkg.sv
// constants shared by both ends of the backplane transceiver link
package bpc_pkg;
  // core clock cycles per half period of the system clock
  localparam logic [3:0] HALF_FAST = 4'h4;
  localparam logic [3:0] HALF_SLOW = 4'h8;
  // link control codes seen on the shared control lines
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_TX = 2'h1;
  localparam logic [1:0] CTL_RX = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  // last dibit and bit index of a byte crossing the link
  localparam logic [1:0] DIBIT_LAST = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // core cycles without a received transition that end a packet
  localparam logic [6:0] RX_IDLE_CYCLES = 7'h40;
  // register byte offsets and status bit positions of the link end
  localparam logic [3:0] REG_TX = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RX = 4'h8;
  localparam int ST_BUSY = 0;
  localparam int ST_RX_VALID = 1;
endpackage : bpc_pkg

// ### testbench/backplane_phy_pin_control_bench.sv
// self-checking bench joining both ends of the backplane link
`timescale 1ns/1ps
module backplane_phy_pin_control_bench;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic strap = 1'b0;
  logic toe = 1'b1;
  logic rx_d = 1'b0;
  logic rx_s = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic avs_wait, txd, txs, lde_n, arb, arb_oe_n, di, di_oe_n, pfx, pfx_oe_n;
  logic [31:0] exp_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] tx_sh = 8'h00;
  logic x_q = 1'b0;
  int tx_cnt = 8;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  bpc_link_if bpc_link_if_i();
  bpc_phy bpc_phy_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .lnk(bpc_link_if_i), .freq_select_strap_i(strap),
    .test_output_enable_i(toe), .rx_data_i(rx_d), .rx_strobe_in_i(rx_s), .tx_data_o(txd), .tx_strobe_out_o(txs),
    .line_driver_enable_n_o(lde_n), .arbitration_clock_test_out_o(arb), .arbitration_clock_test_out_oe_n_o(arb_oe_n),
    .drive_indicator_test_out_o(di), .drive_indicator_test_out_oe_n_o(di_oe_n), .receive_prefix_test_out_o(pfx),
    .receive_prefix_test_out_oe_n_o(pfx_oe_n));
  bpc_link bpc_link_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .lnk(bpc_link_if_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(avs_wait));
  bpc_link_assertions bpc_link_assertions_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .system_clock_out(bpc_link_if_i.system_clock_out),
    .system_clock_inverted_out(bpc_link_if_i.system_clock_inverted_out),
    .service_request_in(bpc_link_if_i.service_request_in), .dev_drive_n(bpc_link_if_i.dev_drive_n),
    .lnk_drive_n(bpc_link_if_i.lnk_drive_n), .link_control(bpc_link_if_i.link_control),
    .test_output_enable_i(toe), .tx_data_o(txd), .tx_strobe_out_o(txs), .line_driver_enable_n_o(lde_n),
    .arbitration_clock_test_out_o(arb), .arbitration_clock_test_out_oe_n_o(arb_oe_n),
    .drive_indicator_test_out_o(di));
  always #10 clk_sys_i = ~clk_sys_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // one avalon cycle; a read notes its expected data first
  task avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    if (!w) begin
      exp_q.push_back(d);
    end
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= w ? d : 32'h0;
    do @(posedge clk_sys_i); while (avs_wait !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : avs
  // data-strobe encoded byte, msb first, 8 core cycles a bit
  task send_rx(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      if (b[i] == rx_d) begin
        rx_s <= ~rx_s;
      end
      rx_d <= b[i];
      repeat (8) @(posedge clk_sys_i);
      if (i == 6) begin
        chk(pfx, 1'b1);
      end
    end
  endtask : send_rx
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end
  // read answers and decoded transmit bytes against the oldest notes
  always @(posedge clk_sys_i) begin
    if (rd && avs_wait === 1'b0) begin
      chk(rdat, exp_q.pop_front());
    end
    if (lde_n === 1'b0 && (txd ^ txs) !== x_q && tx_cnt < 8) begin
      tx_sh = {tx_sh[6:0], txd};
      tx_cnt++;
      if (tx_cnt == 8) begin
        chk(tx_sh, tx_q.pop_front());
      end
    end
    x_q = txd ^ txs;
  end
  initial begin
    logic [7:0] b;
    void'($urandom(80));
    for (int r = 0; r < 2; r++) begin
      strap <= r[0];
      resetn_i <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      chk(lde_n, 1'b1);
      chk(pfx_oe_n, 1'b1);
      chk(di_oe_n, 1'b1);
      resetn_i <= 1'b1;
      avs(1'b0, bpc_pkg::REG_STATUS, 32'h0);
      avs(1'b0, 4'hC, 32'h0);
      chk(di, 1'b0);
      b = 8'($urandom_range(255));
      tx_q.push_back(b);
      tx_cnt = 0;
      avs(1'b1, bpc_pkg::REG_TX, {24'h0, b});
      avs(1'b0, bpc_pkg::REG_STATUS, 32'h1);
      wait (tx_cnt == 8);
      avs(1'b0, bpc_pkg::REG_STATUS, 32'h0);
      $display("test transmit at rate %0d done", r);
      b = 8'($urandom_range(255));
      send_rx(b);
      repeat (100) @(posedge clk_sys_i);
      chk(pfx, 1'b0);
      avs(1'b0, bpc_pkg::REG_STATUS, 32'h2);
      avs(1'b0, bpc_pkg::REG_RX, {24'h0, b});
      avs(1'b0, bpc_pkg::REG_STATUS, 32'h0);
      $display("test receive at rate %0d done", r);
    end
    toe <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk(pfx_oe_n, 1'b0);
    chk(di_oe_n, 1'b0);
    $display("test output enable done");
    end_of_test();
  end
endmodule : backplane_phy_pin_control_bench

// ### testbench/bpc_link_assertions.sv
// concurrent checks on the shared link lines and the transceiver pins
`timescale 1ns/1ps
module bpc_link_assertions (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic system_clock_out,
  input wire logic system_clock_inverted_out,
  input wire logic service_request_in,
  input wire logic dev_drive_n,
  input wire logic lnk_drive_n,
  input wire logic [1:0] link_control,
  input wire logic test_output_enable_i,
  input wire logic tx_data_o,
  input wire logic tx_strobe_out_o,
  input wire logic line_driver_enable_n_o,
  input wire logic arbitration_clock_test_out_o,
  input wire logic arbitration_clock_test_out_oe_n_o,
  input wire logic drive_indicator_test_out_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  logic sclk_q_r;
  logic seen_r;
  logic run_r;
  logic [3:0] half_cnt_r;
  wire sclk_edge = system_clock_out != sclk_q_r;
  // counts core cycles since the last system clock change
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sclk_q_r <= 1'b0;
      seen_r <= 1'b0;
      run_r <= 1'b0;
      half_cnt_r <= 4'h0;
    end else begin
      sclk_q_r <= system_clock_out;
      seen_r <= seen_r | sclk_edge;
      run_r <= 1'b1;
      // release stands for a clock change, which this counter sees one edge late, so the count starts one later
      half_cnt_r <= (sclk_edge || !run_r) ? 4'h0 : half_cnt_r + 4'h1;
    end
  end
  a_clock_inverted: assert property (system_clock_inverted_out == !system_clock_out)
    else $error("inverted system clock does not mirror system clock");
  a_sclk_half_length: assert property (sclk_edge && seen_r |-> half_cnt_r == 4'h3 || half_cnt_r == 4'h7)
    else $error("system clock half period is neither 4 nor 8 cycles");
  a_sclk_keeps_running: assert property (half_cnt_r < 4'h8)
    else $error("system clock stopped");
  a_arb_clock_period: assert property ($changed(arbitration_clock_test_out_o) |=>
    $stable(arbitration_clock_test_out_o) [*3] ##1 $changed(arbitration_clock_test_out_o))
    else $error("arbitration clock half period is not 4 cycles");
  a_drive_indicator: assert property ($past(resetn_i) |-> drive_indicator_test_out_o == dev_drive_n)
    else $error("drive indicator does not follow line drive");
  a_single_driver: assert property (dev_drive_n || lnk_drive_n)
    else $error("both ends drive the shared lines");
  a_grant_on_request: assert property ($rose(link_control == bpc_pkg::CTL_GRANT) |-> service_request_in)
    else $error("grant without a service request");
  a_test_oe_follow: assert property ($stable(test_output_enable_i) [*4] |->
    arbitration_clock_test_out_oe_n_o == test_output_enable_i)
    else $error("test pin enable does not follow its input");
  a_tx_needs_enable: assert property ($changed(tx_data_o) || $changed(tx_strobe_out_o) |->
    !line_driver_enable_n_o || $past(!line_driver_enable_n_o))
    else $error("transmit pair moved with line drivers off");
  a_ds_one_change: assert property (!line_driver_enable_n_o && $past(!line_driver_enable_n_o) |->
    !($changed(tx_data_o) && $changed(tx_strobe_out_o)))
    else $error("data and strobe changed together");
endmodule : bpc_link_assertions
